/* verilog/esp_pkg.sv */
// esp_pkg: constants for the encoder simple positioning block.
// assumes a single 50 MHz system clock and classic wishbone register access.
package esp_pkg;
  // pulse mode codes
  localparam logic [1:0] PM_SINGLE = 2'h0;
  localparam logic [1:0] PM_QUAD1  = 2'h1;
  localparam logic [1:0] PM_QUAD2  = 2'h2;
  localparam logic [1:0] PM_DIR    = 2'h3;
  localparam logic [1:0] RST_KEEP  = 2'h3;   // reset mode that keeps the counter
  localparam logic [7:0] OUT_SEL_DEV = 8'h16; // output function code 22
  // register word offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LIMFWD = 8'h04;
  localparam logic [7:0] REG_LIMREV = 8'h08;
  localparam logic [7:0] REG_DEVLVL = 8'h0C;
  localparam logic [7:0] REG_STAT   = 8'h10;
  localparam logic [7:0] REG_POS    = 8'h14;
  localparam logic [7:0] REG_TGT0   = 8'h20;  // eight targets at 0x20..0x3C
  // ctrl field positions
  localparam int CTL_PMODE   = 0;   // [1:0]
  localparam int CTL_FBSEL   = 2;   // [3:2]
  localparam int CTL_POSEN   = 4;
  localparam int CTL_ROUTE   = 5;
  localparam int CTL_RSTMODE = 6;   // [7:6]
  localparam int CTL_OUTSEL  = 8;   // [15:8]
  localparam int CTL_SELASGN = 16;
  localparam logic [1:0] FBSEL_ENC = 2'h1;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] LIMIT_MAX  = 32'h0FFF_FFFF;  // 268435455
  localparam logic [31:0] DEV_RST    = 32'h0000_0000;
  localparam int POS_W   = 32;
  localparam int DISP_W  = 16;      // top 16 bits of position magnitude
endpackage

/* verilog/esp_positioner.sv */
// esp_positioner: encoder counting, target compare and run/brake decisions.
// assumes all inputs synchronous to REF_CLK and a wishbone classic master.
`timescale 1ns/100ps
`default_nettype none
module esp_positioner #(
  parameter int POS_W = esp_pkg::POS_W
) (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  // wishbone classic slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // field inputs
  input  wire logic        PULSE_INPUT_A,
  input  wire logic        PULSE_INPUT_B_DIRECTION,
  input  wire logic        FORWARD_RUN_COMMAND,
  input  wire logic        REVERSE_RUN_COMMAND,
  input  wire logic        COUNTER_CLEAR_INPUT,
  input  wire logic        SPEED_POSITION_SWITCH,
  input  wire logic        HOMING_TRIGGER,
  input  wire logic        RESET_INPUT,
  input  wire logic        POSITION_SELECT_BIT0,
  input  wire logic        POSITION_SELECT_BIT1,
  input  wire logic        POSITION_SELECT_BIT2,
  input  wire logic        TORQUE_CONTROL_ENABLE,
  input  wire logic [15:0] SPEED_ERROR,
  // drive decisions
  output logic             RUN_FORWARD,
  output logic             RUN_REVERSE,
  output logic             DC_BRAKE,
  output logic             COAST,
  output logic             TORQUE_CONTROL_ACTIVE,
  output logic             POSITION_RANGE_TRIP,
  output logic             POSITIONING_DONE_FLAG,
  output logic             SPEED_DEVIATION_FLAG,
  output logic             DEVIATION_OUTPUT,
  output logic [15:0]      POSITION_DISPLAY
);

  // ****************************************************
  // state and registers
  // ****************************************************
  typedef enum logic [3:0] {
    ESP_IDLE  = 4'b0001,
    ESP_MOVE  = 4'b0010,
    ESP_BRAKE = 4'b0100,
    ESP_TRIP  = 4'b1000
  } esp_state_t;

  esp_state_t              state_q;
  logic [31:0]             ctrl_q;
  logic signed [POS_W-1:0] lim_fwd_q;
  logic signed [POS_W-1:0] lim_rev_q;
  logic [15:0]             dev_lvl_q;
  logic signed [POS_W-1:0] tgt_q [8];
  logic signed [POS_W-1:0] pos_q;
  logic                    a_q;
  logic                    b_q;
  logic                    dir_q;
  logic                    ack_q;

  logic [1:0]  pmode;
  logic        fb_en;
  logic        pos_en;
  logic        run_cmd;
  logic        wb_req;
  logic        wb_wr;
  logic [2:0]  sel_idx;
  logic signed [POS_W-1:0] target;
  logic signed [POS_W-1:0] diff;
  logic signed [POS_W-1:0] wrap_diff;
  logic signed [POS_W-1:0] eff_diff;
  logic        step;
  logic        step_up;
  logic        clr_cnt;
  logic        out_range;

  assign pmode   = ctrl_q[esp_pkg::CTL_PMODE +: 2];
  assign fb_en   = ctrl_q[esp_pkg::CTL_FBSEL +: 2] == esp_pkg::FBSEL_ENC;
  assign pos_en  = ctrl_q[esp_pkg::CTL_POSEN] && fb_en;
  assign run_cmd = FORWARD_RUN_COMMAND | REVERSE_RUN_COMMAND;
  assign wb_req  = WB_CYC_I && WB_STB_I && !ack_q;
  assign wb_wr   = wb_req && WB_WE_I;

  // ****************************************************
  // target selection
  // ****************************************************
  // binary select index
  always_comb begin
    // unassigned inputs fall back to zero
    if (ctrl_q[esp_pkg::CTL_SELASGN]) begin
      sel_idx = {POSITION_SELECT_BIT2, POSITION_SELECT_BIT1, POSITION_SELECT_BIT0};
    end else begin
      sel_idx = 3'h0;
    end
  end
  assign target = tgt_q[sel_idx];

  // ****************************************************
  // pulse decoding
  // ****************************************************
  // mode dependent step detection
  always_comb begin
    step    = 1'b0;
    step_up = dir_q;
    case (pmode)
      esp_pkg::PM_SINGLE: begin
        step    = PULSE_INPUT_A && !a_q;
        step_up = 1'b1;   // one phase carries no direction, so never inherit a stale one
      end
      esp_pkg::PM_DIR: begin
        step    = PULSE_INPUT_A && !a_q;
        step_up = PULSE_INPUT_B_DIRECTION;
      end
      default: begin
        step = (PULSE_INPUT_A != a_q) ^ (PULSE_INPUT_B_DIRECTION != b_q);
        if (step) begin
          step_up = (PULSE_INPUT_A != a_q) ? (PULSE_INPUT_A != PULSE_INPUT_B_DIRECTION)
                                           : (PULSE_INPUT_A == PULSE_INPUT_B_DIRECTION);
        end else if (pmode == esp_pkg::PM_QUAD2 && run_cmd) begin
          step_up = FORWARD_RUN_COMMAND;
        end else begin
          step_up = dir_q;   // keep last direction
        end
      end
    endcase
  end

  // an edge on both phases at once is not decodable: in the quadrature modes it is dropped
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      a_q   <= 1'b0;
      b_q   <= 1'b0;
      dir_q <= 1'b1;
    end else if (CLK_EN) begin
      a_q   <= PULSE_INPUT_A;
      b_q   <= PULSE_INPUT_B_DIRECTION;
      dir_q <= step_up;
    end
  end

  // ****************************************************
  // position counter
  // ****************************************************
  // clear sources
  // reset input clears unless reset mode keeps it
  assign clr_cnt = (COUNTER_CLEAR_INPUT && (pmode != esp_pkg::PM_SINGLE || run_cmd))
                 || SPEED_POSITION_SWITCH || HOMING_TRIGGER
                 || (RESET_INPUT && ctrl_q[esp_pkg::CTL_RSTMODE +: 2] != esp_pkg::RST_KEEP);

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pos_q <= '0;
    end else if (CLK_EN) begin
      if (clr_cnt) begin
        pos_q <= '0;
      end else if (fb_en && step) begin
        pos_q <= step_up ? pos_q + POS_W'(1) : pos_q - POS_W'(1);
      end
    end
  end

  // ****************************************************
  // direction decision
  // ****************************************************
  assign diff = target - pos_q;
  // shorter way on a rotating axis, revolution count in target zero
  always_comb begin
    wrap_diff = diff;
    if (diff > (tgt_q[0] >>> 1)) begin
      wrap_diff = diff - tgt_q[0];
    end else if (diff < -(tgt_q[0] >>> 1)) begin
      wrap_diff = diff + tgt_q[0];
    end
  end
  assign eff_diff = (ctrl_q[esp_pkg::CTL_ROUTE] && tgt_q[0] > 0
                     && (pmode == esp_pkg::PM_SINGLE || pmode == esp_pkg::PM_QUAD1))
                    ? wrap_diff : diff;
  assign out_range = pos_q > lim_fwd_q || pos_q < lim_rev_q;

  // speed and ramps stay with the drive; only direction and stop come from here
  // deceleration start is the ramp generator's business
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ESP_IDLE;
    end else if (CLK_EN) begin
      case (state_q)
        ESP_IDLE: begin
          if (pos_en && out_range) begin
            state_q <= ESP_TRIP;
          end else if (pos_en && run_cmd && !SPEED_POSITION_SWITCH) begin
            state_q <= (target == 0 || eff_diff == 0) ? ESP_BRAKE : ESP_MOVE;
          end
        end
        ESP_MOVE: begin
          if (out_range) begin
            state_q <= ESP_TRIP;
          end else if (!run_cmd || !pos_en) begin
            state_q <= ESP_IDLE;
          end else if (eff_diff == 0) begin
            state_q <= ESP_BRAKE;
          end
        end
        ESP_BRAKE: begin
          if (out_range) begin
            state_q <= ESP_TRIP;
          end else if (!run_cmd) begin
            state_q <= ESP_IDLE;
          end
        end
        ESP_TRIP: begin
          // trip stays until the reset input
          if (RESET_INPUT) begin
            state_q <= ESP_IDLE;
          end
        end
        default: state_q <= ESP_IDLE;
      endcase
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  // registered so every output is a flop
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RUN_FORWARD           <= 1'b0;
      RUN_REVERSE           <= 1'b0;
      DC_BRAKE              <= 1'b0;
      COAST                 <= 1'b0;
      POSITION_RANGE_TRIP   <= 1'b0;
      POSITIONING_DONE_FLAG <= 1'b0;
      TORQUE_CONTROL_ACTIVE <= 1'b0;
      SPEED_DEVIATION_FLAG  <= 1'b0;
      DEVIATION_OUTPUT      <= 1'b0;
      POSITION_DISPLAY      <= 16'h0000;
    end else if (CLK_EN) begin
      RUN_FORWARD <= state_q == ESP_MOVE && eff_diff > 0;
      RUN_REVERSE <= state_q == ESP_MOVE && eff_diff < 0;
      DC_BRAKE    <= state_q == ESP_BRAKE;
      COAST               <= state_q == ESP_TRIP;
      POSITION_RANGE_TRIP <= state_q == ESP_TRIP;
      POSITIONING_DONE_FLAG <= state_q == ESP_BRAKE;
      TORQUE_CONTROL_ACTIVE <= TORQUE_CONTROL_ENABLE && !pos_en;
      // deviation flag and its output function
      SPEED_DEVIATION_FLAG <= SPEED_ERROR > dev_lvl_q;
      DEVIATION_OUTPUT     <= (SPEED_ERROR > dev_lvl_q)
                              && ctrl_q[esp_pkg::CTL_OUTSEL +: 8] == esp_pkg::OUT_SEL_DEV;
      // top four digits: value divided by 10^5 is too wide for a
      // cheap divider, so the top 16 bits of magnitude are shown instead
      POSITION_DISPLAY <= pos_q[POS_W-1] ? 16'(((-pos_q) >>> (POS_W - 16)))
                                         : 16'(pos_q >>> (POS_W - 16));
    end
  end

  // ****************************************************
  // wishbone register file
  // ****************************************************
  // one-cycle answer; ack drops the cycle after
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_q    <= 1'b0;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else if (CLK_EN) begin
      ack_q    <= wb_req;
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          esp_pkg::REG_CTRL:   WB_DAT_O <= ctrl_q;
          esp_pkg::REG_LIMFWD: WB_DAT_O <= 32'(lim_fwd_q);
          esp_pkg::REG_LIMREV: WB_DAT_O <= 32'(lim_rev_q);
          esp_pkg::REG_DEVLVL: WB_DAT_O <= {16'h0000, dev_lvl_q};
          esp_pkg::REG_STAT:   WB_DAT_O <= {24'h00_0000, 1'b0, state_q, out_range,
                                            SPEED_DEVIATION_FLAG, dir_q};
          esp_pkg::REG_POS:    WB_DAT_O <= 32'(pos_q);
          default: begin
            if (WB_ADR_I[7:5] == 3'h1 && WB_ADR_I[1:0] == 2'h0) begin
              WB_DAT_O <= 32'(tgt_q[WB_ADR_I[4:2]]);
            end else begin
              WB_DAT_O <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

  // software writes, byte lanes honoured
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q    <= esp_pkg::CTRL_RST;
      lim_fwd_q <= POS_W'(esp_pkg::LIMIT_MAX);
      lim_rev_q <= -POS_W'(esp_pkg::LIMIT_MAX);
      dev_lvl_q <= 16'(esp_pkg::DEV_RST);
    end else if (CLK_EN && wb_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (WB_SEL_I[i]) begin
          case (WB_ADR_I)
            esp_pkg::REG_CTRL:   ctrl_q[i*8 +: 8]    <= WB_DAT_I[i*8 +: 8];
            esp_pkg::REG_LIMFWD: lim_fwd_q[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
            esp_pkg::REG_LIMREV: lim_rev_q[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
            esp_pkg::REG_DEVLVL: if (i < 2) dev_lvl_q[i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  // target table, one generate entry per stored position
  for (genvar g = 0; g < 8; g++) begin : g_tgt
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        tgt_q[g] <= '0;
      end else if (CLK_EN && wb_wr && WB_ADR_I == esp_pkg::REG_TGT0 + 8'(g * 4)) begin
        for (int i = 0; i < 4; i++) begin
          if (WB_SEL_I[i]) begin
            tgt_q[g][i*8 +: 8] <= WB_DAT_I[i*8 +: 8];
          end
        end
      end
    end
  end

endmodule // esp_positioner
`default_nettype wire

/* dv/esp_encoder_model.sv */
// esp_encoder_model: incremental encoder on the pulse inputs.
// assumes the bench raises req for one cycle while busy is low.
`timescale 1ns/100ps
`default_nettype none
module esp_encoder_model #(
  parameter int GAP = 4  // edge spacing, far shorter than the real rate limit
) (
  input  wire logic clk,
  input  wire logic quad,
  input  wire logic up,
  input  wire logic req,
  output logic      busy,
  output logic      ch_a,
  output logic      ch_b
);
  // ************
  // step engine
  // ************
  logic [1:0] ph_q  = 2'h0;
  logic       hi_q  = 1'b0;
  logic       dir_q = 1'b0;
  int         wait_q = 0;
  always_ff @(posedge clk) begin
    if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (hi_q) begin
      hi_q   <= 1'b0;
      wait_q <= GAP;
    end else if (req) begin
      wait_q <= GAP;
      dir_q  <= up;
      if (quad) begin
        ph_q <= up ? ph_q + 2'h1 : ph_q - 2'h1;
      end else begin
        hi_q <= 1'b1;
      end
    end
  end
  // direction level on b; phase a leads b going up
  assign ch_a = quad ? ph_q[1] ^ ph_q[0] : hi_q;
  assign ch_b = quad ? ph_q[1] : dir_q;
  assign busy = hi_q || (wait_q != 0);
endmodule // esp_encoder_model
`default_nettype wire

/* dv/esp_positioner_chk.sv */
// esp_positioner_chk: port-level assertions for the positioner.
// assumes it is bound to esp_positioner and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module esp_positioner_chk (
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        CLK_EN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic        FORWARD_RUN_COMMAND,
  input wire logic        REVERSE_RUN_COMMAND,
  input wire logic        RESET_INPUT,
  input wire logic        RUN_FORWARD,
  input wire logic        RUN_REVERSE,
  input wire logic        DC_BRAKE,
  input wire logic        COAST,
  input wire logic        POSITION_RANGE_TRIP,
  input wire logic        POSITIONING_DONE_FLAG,
  input wire logic [15:0] POSITION_DISPLAY
);
  // either command only means run
  wire logic run_cmd = FORWARD_RUN_COMMAND | REVERSE_RUN_COMMAND;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // command gone long enough for state and output lag
  sequence run_gone_s;
    (!run_cmd && CLK_EN) [*3];
  endsequence
  // ************
  // assertions
  // ************
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && CLK_EN && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acked");
  dir_excl_a: assert property (
    !(RUN_FORWARD && RUN_REVERSE)) else $error("both directions driven");
  run_cause_a: assert property (
    (RUN_FORWARD || RUN_REVERSE) |-> $past(run_cmd, 2)) else $error("run without command");
  brake_hold_a: assert property (
    DC_BRAKE && run_cmd && CLK_EN |=> DC_BRAKE) else $error("brake dropped early");
  brake_release_a: assert property (
    run_gone_s |-> !DC_BRAKE && !POSITIONING_DONE_FLAG) else $error("brake kept");
  brake_stop_a: assert property (
    DC_BRAKE |-> !RUN_FORWARD && !RUN_REVERSE) else $error("run while braking");
  done_brake_a: assert property (
    POSITIONING_DONE_FLAG |-> DC_BRAKE) else $error("done without brake");
  trip_coast_a: assert property (
    POSITION_RANGE_TRIP |-> COAST && !RUN_FORWARD && !RUN_REVERSE)
    else $error("trip without coast");
  trip_hold_a: assert property (
    POSITION_RANGE_TRIP && !RESET_INPUT && !$past(RESET_INPUT) |=> POSITION_RANGE_TRIP)
    else $error("trip lost without reset input");
  home_zero_a: assert property (
    $fell(SYS_RST) |-> POSITION_DISPLAY == 16'h0000) else $error("home not zero");
endmodule // esp_positioner_chk
bind esp_positioner esp_positioner_chk esp_positioner_chk_inst (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .FORWARD_RUN_COMMAND(FORWARD_RUN_COMMAND),
  .REVERSE_RUN_COMMAND(REVERSE_RUN_COMMAND), .RESET_INPUT(RESET_INPUT),
  .RUN_FORWARD(RUN_FORWARD), .RUN_REVERSE(RUN_REVERSE), .DC_BRAKE(DC_BRAKE), .COAST(COAST),
  .POSITION_RANGE_TRIP(POSITION_RANGE_TRIP), .POSITIONING_DONE_FLAG(POSITIONING_DONE_FLAG),
  .POSITION_DISPLAY(POSITION_DISPLAY));
`default_nettype wire

/* dv/encoder_simple_positioning_test.sv */
// encoder_simple_positioning_test: self-checking bench for esp_positioner.
// assumes the encoder model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module encoder_simple_positioning_test;
  logic clk, rst, cyc, stb, we, ack, ea, eb, fw, rv, counter_clear_input, speed_position_switch, homing_trigger, rsi, tqe;
  logic quad, up, req, busy, rfw, rrv, dcb, cst, tqa, trp, done, dflg, dvo;
  logic [2:0]  ps;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [15:0] serr, disp;
  logic [31:0] wdat, rdat;
  int          n_fail = 0;
  int          n_tests = 0;
  localparam logic [31:0] ENC_C = 32'(esp_pkg::FBSEL_ENC) << esp_pkg::CTL_FBSEL;
  localparam logic [31:0] POS_C = 32'h0000_0001 << esp_pkg::CTL_POSEN;
  localparam logic [31:0] SEL_C = 32'h0000_0001 << esp_pkg::CTL_SELASGN;
  esp_positioner esp_positioner_inst (
    .REF_CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PULSE_INPUT_A(ea), .PULSE_INPUT_B_DIRECTION(eb),
    .FORWARD_RUN_COMMAND(fw), .REVERSE_RUN_COMMAND(rv), .COUNTER_CLEAR_INPUT(counter_clear_input),
    .SPEED_POSITION_SWITCH(speed_position_switch), .HOMING_TRIGGER(homing_trigger), .RESET_INPUT(rsi),
    .POSITION_SELECT_BIT0(ps[0]), .POSITION_SELECT_BIT1(ps[1]), .POSITION_SELECT_BIT2(ps[2]),
    .TORQUE_CONTROL_ENABLE(tqe), .SPEED_ERROR(serr), .RUN_FORWARD(rfw), .RUN_REVERSE(rrv),
    .DC_BRAKE(dcb), .COAST(cst), .TORQUE_CONTROL_ACTIVE(tqa), .POSITION_RANGE_TRIP(trp),
    .POSITIONING_DONE_FLAG(done), .SPEED_DEVIATION_FLAG(dflg), .DEVIATION_OUTPUT(dvo),
    .POSITION_DISPLAY(disp));
  esp_encoder_model esp_encoder_model_inst (
    .clk(clk), .quad(quad), .up(up), .req(req), .busy(busy), .ch_a(ea), .ch_b(eb));
  // ************
  // shared tasks
  // ************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk("read data", exp, rdat);
  endtask
  // one model step each, then let counter, state and outputs settle
  task automatic step(input int n, input logic dir);
    int i;
    repeat (n) begin
      up <= dir;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (busy && i < 100);
      if (i >= 100) begin
        n_fail++;
        print_verdict();
      end
    end
    tick(4);
  endtask
  // k: 0 clear input, 1 speed switch, 2 homing, 3 reset input
  task automatic pulse_in(input int k);
    {rsi, homing_trigger, speed_position_switch, counter_clear_input} <= 4'b0001 << k;
    tick(3);
    {rsi, homing_trigger, speed_position_switch, counter_clear_input} <= 4'h0;
    tick(3);
  endtask
  // ************
  // scenarios
  // ************
  task automatic t_regs;
    rd(esp_pkg::REG_CTRL, esp_pkg::CTRL_RST);
    rd(esp_pkg::REG_LIMFWD, esp_pkg::LIMIT_MAX);
    rd(esp_pkg::REG_LIMREV, -esp_pkg::LIMIT_MAX);
    wb(1'b1, 8'hFC, 32'h0000_0001);
    rd(8'hFC, 32'h0000_0000);
    wb(1'b1, esp_pkg::REG_POS, 32'h0000_0005);
    rd(esp_pkg::REG_POS, 32'h0000_0000);
    $display("registers done");
  endtask
  task automatic t_count;
    logic [1:0] m;
    for (int k = 1; k <= 4; k++) begin
      m = 2'(k);
      quad <= (m == esp_pkg::PM_QUAD1 || m == esp_pkg::PM_QUAD2);
      wb(1'b1, esp_pkg::REG_CTRL, ENC_C | 32'(m));
      pulse_in(1);
      step(3, 1'b1);
      if (m != esp_pkg::PM_SINGLE) step(1, 1'b0);
      rd(esp_pkg::REG_POS, (m == esp_pkg::PM_SINGLE) ? 32'h0000_0003 : 32'h0000_0002);
    end
    wb(1'b1, esp_pkg::REG_CTRL, 32'h0000_0000);
    step(2, 1'b1);
    rd(esp_pkg::REG_POS, 32'h0000_0003);
    $display("counting done");
  endtask
  task automatic t_move;
    quad <= 1'b1;
    wb(1'b1, esp_pkg::REG_CTRL, ENC_C | POS_C | SEL_C | 32'(esp_pkg::PM_QUAD1));
    wb(1'b1, esp_pkg::REG_TGT0 + 8'h14, 32'h0000_0002);
    wb(1'b1, esp_pkg::REG_TGT0 + 8'h18, 32'hFFFF_FFFF);
    ps <= 3'b101;
    pulse_in(1);
    rv <= 1'b1;
    tick(4);
    chk("forward", 1'b1, rfw);
    step(2, 1'b1);
    chk("brake", 1'b1, dcb);
    chk("done", 1'b1, done);
    tick(6);
    chk("brake held", 1'b1, dcb);
    rv <= 1'b0;
    tick(4);
    chk("brake off", 1'b0, dcb);
    ps <= 3'b110;
    fw <= 1'b1;
    tick(4);
    chk("reverse", 1'b1, rrv);
    step(3, 1'b0);
    chk("done rev", 1'b1, done);
    fw <= 1'b0;
    tick(4);
    $display("moves done");
  endtask
  task automatic t_zero;
    wb(1'b1, esp_pkg::REG_CTRL, ENC_C | POS_C | 32'(esp_pkg::PM_QUAD1));
    ps <= 3'b111;
    fw <= 1'b1;
    tick(4);
    chk("zero done", 1'b1, done);
    chk("zero still", 1'b0, rfw | rrv);
    fw <= 1'b0;
    tick(4);
    $display("zero target done");
  endtask
  task automatic t_clear;
    quad <= 1'b0;
    wb(1'b1, esp_pkg::REG_CTRL, ENC_C | (32'(esp_pkg::RST_KEEP) << esp_pkg::CTL_RSTMODE));
    pulse_in(1);
    step(2, 1'b1);
    pulse_in(0);
    rd(esp_pkg::REG_POS, 32'h0000_0002);
    pulse_in(3);
    rd(esp_pkg::REG_POS, 32'h0000_0002);
    fw <= 1'b1;
    pulse_in(0);
    fw <= 1'b0;
    rd(esp_pkg::REG_POS, 32'h0000_0000);
    wb(1'b1, esp_pkg::REG_CTRL, ENC_C);
    step(1, 1'b1);
    pulse_in(3);
    rd(esp_pkg::REG_POS, 32'h0000_0000);
    step(1, 1'b1);
    pulse_in(2);
    rd(esp_pkg::REG_POS, 32'h0000_0000);
    $display("clearing done");
  endtask
  task automatic t_trip;
    wb(1'b1, esp_pkg::REG_CTRL, ENC_C | POS_C | 32'(esp_pkg::PM_DIR));
    wb(1'b1, esp_pkg::REG_LIMFWD, 32'h0000_0002);
    step(3, 1'b1);
    chk("trip", 1'b1, trp);
    chk("coast", 1'b1, cst);
    pulse_in(3);
    chk("trip clear", 1'b0, trp);
    $display("range trip done");
  endtask
  task automatic t_misc;
    wb(1'b1, esp_pkg::REG_DEVLVL, 32'h0000_000A);
    wb(1'b1, esp_pkg::REG_CTRL, ENC_C | POS_C | (32'(esp_pkg::OUT_SEL_DEV) << 8));
    tqe <= 1'b1;
    serr <= 16'h000B;
    tick(4);
    chk("deviation", 1'b1, dvo);
    chk("torque", 1'b0, tqa);
    serr <= 16'h000A;
    tick(4);
    chk("deviation off", 1'b0, dflg);
    $display("outputs done");
  endtask
  // ************
  // clock and main sequence
  // ************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, cyc, stb, we, fw, rv, counter_clear_input, speed_position_switch, homing_trigger, rsi, tqe, quad, up, req} = 14'h2000;
    {ps, sel, adr, serr, wdat} = {3'h0, 4'hF, 8'h00, 16'h0000, 32'h0000_0000};
    tick(16);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_count();
    t_move();
    t_zero();
    t_clear();
    t_trip();
    t_misc();
    print_verdict();
  end
endmodule // encoder_simple_positioning_test
`default_nettype wire
